// [core/prom_prog_defs.svh]
// Timing counts, widths and reset values for the programming port.
// Functional notes
// - Each word moves serially over the data pin, one bit per rising clock.
// - Select high, output enable high: shift incoming word into program buffer.
// - Select low, output enable high: drive stored word out bit by bit.
// - Address counter advances with select high and output enable low, and after each word is read out.
// - In programming mode the stored reset polarity is ignored.
// - Cascade output shows the configured reset polarity to the programmer, in programming mode only while select is high.
// - Cascade output goes low one cycle after the last bit is read.
// - Reset state held at least 20 ns in programming mode clears the bit counter; in idle, reset clears both counters.
// - Mode is left when select and output enable are both low.
`ifndef PROM_PROG_DEFS_SVH
`define PROM_PROG_DEFS_SVH
`define CLK_PERIOD_PS 20000
`define RST_HOLD_MIN_PS 20000
`define RST_HOLD_CYC ((`RST_HOLD_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PGM_PULSE_MIN_PS 950000000
`define PGM_PULSE_CYC (`PGM_PULSE_MIN_PS / `CLK_PERIOD_PS)
`define WORD_W 8
`define ADDR_W 4
`define FIFO_DEPTH 4
`define POL_RESET_HIGH 1'b1
`endif

// [core/prom_prog_pkg.sv]
// Types shared by the programming port modules.
package prom_prog_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ENTER = 4'b0010,
    ST_ACCESS = 4'b0100,
    ST_PROG = 4'b1000
  } mode_t;
endpackage : prom_prog_pkg

// [core/word_fifo.sv]
// Small valid/ready FIFO for programmed words.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Space available.
  input wire logic [WIDTH-1:0] in_data, // Write data.
  output logic out_valid, // Data available.
  input wire logic out_ready, // Read accept.
  output logic [WIDTH-1:0] out_data // Read data.
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_t;
  fifo_st_t st_r, st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;
  assign empty = (st_r.wp == st_r.rp);
  assign full = (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]) && (st_r.wp[AW] != st_r.rp[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[st_r.rp[AW-1:0]];
  always_comb
  begin
    st_nxt = st_r;
    if (in_valid && !full)
      st_nxt.wp = st_r.wp + 1'b1;
    if (out_ready && !empty)
      st_nxt.rp = st_r.rp + 1'b1;
  end
  always_ff @(posedge clock)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
    if (in_valid && !full)
      mem[st_r.wp[AW-1:0]] <= in_data;
  end
endmodule : word_fifo
`default_nettype wire

// [core/prom_prog_port.sv]
// Programming-mode serial port of a one-time-programmable configuration memory.
`timescale 1ns/1ps
`default_nettype none
`include "prom_prog_defs.svh"
module prom_prog_port
  import prom_prog_pkg::*;
#(
  parameter int WORD_W = `WORD_W,
  parameter int ADDR_W = `ADDR_W,
  parameter int PGM_CYC = `PGM_PULSE_CYC
) (
  input wire logic clock, // System clock, 50 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic clk_rise, // One-cycle pulse at each serial clock rising edge.
  input wire logic sel, // Chip select level.
  input wire logic oe_reset, // Counter-reset/output-enable level.
  input wire logic program_pulse_level, // Supply at programming level.
  input wire logic mode_access_level, // Supply at mode access level.
  input wire logic data_in, // Data pin input.
  output logic data_out, // Data pin output.
  output logic data_oe, // Data pin output enable.
  output logic cascade_select_out, // Cascade enable output.
  output logic prog_mode, // High while in programming mode.
  output logic wr_valid, // Committed word available to the array.
  output logic [WORD_W-1:0] wr_data, // Committed word.
  output logic [ADDR_W-1:0] wr_addr, // Address of committed word.
  input wire logic wr_ready, // Array accepts committed word.
  output logic [ADDR_W-1:0] rd_addr, // Address of word being read.
  input wire logic [WORD_W-1:0] rd_word, // Stored word at rd_addr.
  input wire logic reset_pol // Programmed reset polarity, 1 = active high.
);
  localparam int BW = $clog2(WORD_W);
  typedef struct packed {
    mode_t mode;
    logic [1:0] edges;
    logic [ADDR_W-1:0] addr;
    logic [BW-1:0] bitc;
    logic [WORD_W-1:0] buf_w;
    logic [WORD_W-1:0] sh_out;
    logic out_en;
    logic dout;
    logic last_done;
    logic cso;
    logic pp_d;
    logic [$clog2(`RST_HOLD_CYC+1):0] rst_cnt;
    logic [31:0] pgm_cnt;
  } port_st_t;
  port_st_t st_r, st_nxt;
  logic fifo_in_ready, fifo_in_valid, fifo_out_valid;
  logic [WORD_W+ADDR_W-1:0] fifo_out;
  word_fifo #(.WIDTH(WORD_W + ADDR_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({st_r.addr, st_r.buf_w}),
    .out_valid(fifo_out_valid),
    .out_ready(wr_ready && wr_valid),
    .out_data(fifo_out)
  );
  always_comb
  begin
    st_nxt = st_r;
    fifo_in_valid = 1'b0;
    st_nxt.pp_d = program_pulse_level;
    case (st_r.mode)
      ST_IDLE:
      begin
        st_nxt.edges = 2'd0;
        // Outside programming mode the stored polarity is shown.
        st_nxt.cso = reset_pol;
        // Outside programming mode the stored polarity decides what counts as reset.
        if (oe_reset == reset_pol)
        begin
          st_nxt.addr = '0;
          st_nxt.bitc = '0;
          st_nxt.last_done = 1'b0;
        end
        if (clk_rise && sel && oe_reset && program_pulse_level)
        begin
          st_nxt.edges = st_r.edges + 2'd1;
          st_nxt.mode = ST_ENTER;
        end
      end
      ST_ENTER:
      begin
        if (clk_rise)
        begin
          if (program_pulse_level && sel && oe_reset)
            st_nxt.edges = st_r.edges + 2'd1;
          else if (mode_access_level && st_r.edges >= 2'd2)
          begin
            st_nxt.mode = ST_ACCESS;
            st_nxt.addr = '0;
            st_nxt.bitc = '0;
          end
          else
            st_nxt.mode = ST_IDLE;
        end
      end
      default:
      begin
        // Pin is read with the default polarity: high means reset/enable.
        if (!sel && !oe_reset)
        begin
          st_nxt.mode = ST_IDLE;
          st_nxt.out_en = 1'b0;
        end
        else
        begin
          if (oe_reset && sel)
            st_nxt.rst_cnt = (st_r.rst_cnt < `RST_HOLD_CYC) ? st_r.rst_cnt + 1'b1 : st_r.rst_cnt;
          else
            st_nxt.rst_cnt = '0;
          if (clk_rise)
          begin
            if (sel && oe_reset)
            begin
              st_nxt.buf_w = {st_r.buf_w[WORD_W-2:0], data_in};
              st_nxt.out_en = 1'b0;
            end
            else if (!sel && oe_reset)
            begin
              st_nxt.out_en = !st_r.last_done;
              st_nxt.dout = rd_word[WORD_W-1-st_r.bitc];
              if (st_r.last_done)
                st_nxt.cso = 1'b0;
              else if (st_r.bitc == BW'(WORD_W - 1))
              begin
                st_nxt.bitc = '0;
                st_nxt.addr = st_r.addr + 1'b1;
                if (&st_r.addr)
                  st_nxt.last_done = 1'b1;
              end
              else
                st_nxt.bitc = st_r.bitc + 1'b1;
            end
            else if (sel && !oe_reset)
            begin
              st_nxt.addr = st_r.addr + 1'b1;
              st_nxt.bitc = '0;
              st_nxt.out_en = 1'b0;
            end
          end
          // A reset pulse of the minimum width clears the bit counter.
          if (st_r.rst_cnt == `RST_HOLD_CYC && !st_r.last_done && !clk_rise)
            st_nxt.bitc = '0;
          // Programming pulse start commits the buffered word.
          if (program_pulse_level && !st_r.pp_d && fifo_in_ready)
          begin
            fifo_in_valid = 1'b1;
            st_nxt.mode = ST_PROG;
          end
          if (st_r.mode == ST_PROG && !program_pulse_level)
            st_nxt.mode = ST_ACCESS;
          if (sel)
            st_nxt.cso = reset_pol;
        end
      end
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.mode <= ST_IDLE;
      st_r.cso <= `POL_RESET_HIGH;
    end
    else
      st_r <= st_nxt;
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      data_out <= 1'b0;
      data_oe <= 1'b0;
      cascade_select_out <= 1'b1;
      prog_mode <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= '0;
      wr_addr <= '0;
      rd_addr <= '0;
    end
    else
    begin
      data_out <= st_nxt.dout;
      data_oe <= st_nxt.out_en && (st_nxt.mode != ST_IDLE);
      cascade_select_out <= st_nxt.cso;
      prog_mode <= (st_nxt.mode == ST_ACCESS) || (st_nxt.mode == ST_PROG);
      wr_valid <= fifo_out_valid && !(wr_valid && wr_ready);
      wr_data <= fifo_out[WORD_W-1:0];
      wr_addr <= fifo_out[WORD_W+ADDR_W-1:WORD_W];
      rd_addr <= st_nxt.addr;
    end
  end
endmodule : prom_prog_port
`default_nettype wire

// [verif/prom_prog_port_sva.sv]
// Checker for the programming port pins.
`timescale 1ns/1ps
`default_nettype none
module prom_prog_port_sva #(
  parameter int WORD_W = 8,
  parameter int ADDR_W = 4
) (
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic clk_rise, // Serial edge.
  input wire logic sel, // Select.
  input wire logic oe_reset, // Reset/enable.
  input wire logic reset_pol, // Polarity.
  input wire logic data_oe, // Pin enable.
  input wire logic cascade_select_out, // Cascade.
  input wire logic prog_mode, // Mode.
  input wire logic wr_valid, // Word valid.
  input wire logic [WORD_W-1:0] wr_data, // Word.
  input wire logic wr_ready, // Accept.
  input wire logic [ADDR_W-1:0] rd_addr // Address.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_load;
    clk_rise && sel && oe_reset ##1 sel ##1 sel;
  endsequence
  sequence s_idle;
    !prog_mode ##1 !prog_mode;
  endsequence
  property p_load_quiet;
    s_load |-> !data_oe;
  endproperty
  a_load_quiet: assert property (p_load_quiet) else $error("pin driven in load");
  property p_idle_quiet;
    s_idle |-> !data_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pin driven idle");
  property p_exit;
    prog_mode && !sel && !oe_reset |-> ##[1:2] !prog_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("mode kept");
  property p_step;
    prog_mode && clk_rise && sel && !oe_reset |=> rd_addr == ADDR_W'($past(rd_addr) + 1);
  endproperty
  a_step: assert property (p_step) else $error("address not stepped");
  property p_drive;
    prog_mode && clk_rise && !sel && oe_reset |=> data_oe || !cascade_select_out;
  endproperty
  a_drive: assert property (p_drive) else $error("read not driven");
  property p_end;
    prog_mode && clk_rise && !sel && oe_reset ##1 $fell(cascade_select_out) |-> !data_oe;
  endproperty
  a_end: assert property (p_end) else $error("pin driven after last bit");
  property p_clear;
    !prog_mode && oe_reset ##1 oe_reset |=> rd_addr == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");
  property p_pol;
    s_idle ##0 $stable(reset_pol) |-> cascade_select_out == reset_pol;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not shown");
  property p_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
endmodule : prom_prog_port_sva
bind prom_prog_port prom_prog_port_sva #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) sva_u (.clock,
  .rst, .clk_rise, .sel, .oe_reset, .reset_pol, .data_oe, .cascade_select_out, .prog_mode,
  .wr_valid, .wr_data, .wr_ready, .rd_addr);
`default_nettype wire

// [verif/prom_programmer.sv]
// Programmer model driving the serial pins.
`timescale 1ns/1ps
`default_nettype none
module prom_programmer #(
  parameter int PGM_CYC = 10
) (
  input wire logic clock, // Clock.
  input wire logic data_out, // Memory drive.
  input wire logic data_oe, // Memory enable.
  output logic clk_rise, // Serial edge.
  output logic sel, // Select.
  output logic oe_reset, // Reset/enable.
  output logic program_pulse_level, // Pulse level.
  output logic mode_access_level, // Access level.
  output var logic data_in // Pin level.
);
  logic drv_r;
  assign data_in = data_oe ? data_out : drv_r;
  initial {clk_rise, sel, oe_reset, program_pulse_level, mode_access_level, drv_r} = 6'h0;
  // Select moves only with a serial edge; a released pin toggles.
  task automatic tick(input logic s, input logic o, input logic d);
    @(posedge clock);
    sel <= s;
    oe_reset <= o;
    drv_r <= s ? d : ~drv_r;
    clk_rise <= 1'b1;
    @(posedge clock);
    clk_rise <= 1'b0;
    @(posedge clock);
  endtask : tick
  task automatic enter();
    @(posedge clock);
    program_pulse_level <= 1'b1;
    repeat (2) tick(1'b1, 1'b1, 1'b0);
    program_pulse_level <= 1'b0;
    mode_access_level <= 1'b1;
    tick(1'b1, 1'b1, 1'b0);
  endtask : enter
  task automatic commit(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) tick(1'b1, 1'b1, w[i]);
    mode_access_level <= 1'b0;
    program_pulse_level <= 1'b1;
    repeat (PGM_CYC) @(posedge clock);
    program_pulse_level <= 1'b0;
    mode_access_level <= 1'b1;
  endtask : commit
endmodule : prom_programmer
`default_nettype wire

// [verif/tb_prom_prog_port.sv]
// Bench for the programming port.
`timescale 1ns/1ps
`default_nettype none
`include "prom_prog_defs.svh"
module tb_prom_prog_port;
  logic clock = 1'b0, rst = 1'b1, wr_ready = 1'b0, reset_pol = 1'b1;
  logic clk_rise, sel, oe_reset, program_pulse_level, mode_access_level;
  logic data_in, data_out, data_oe, cascade_select_out, prog_mode, wr_valid;
  logic [7:0] wr_data, rd_word, w;
  logic [3:0] wr_addr, rd_addr;
  int fail_count = 0, num_checks = 0;
  always #10 clock = ~clock;
  assign rd_word = {rd_addr, ~rd_addr};
  prom_programmer #(.PGM_CYC(`PGM_PULSE_CYC)) prg_u (.clock, .data_out, .data_oe, .clk_rise, .sel,
    .oe_reset, .program_pulse_level, .mode_access_level, .data_in);
  prom_prog_port #(.PGM_CYC(`PGM_PULSE_CYC)) dut_u (.clock, .rst, .clk_rise, .sel, .oe_reset,
    .program_pulse_level, .mode_access_level, .data_in, .data_out, .data_oe,
    .cascade_select_out, .prog_mode, .wr_valid, .wr_data, .wr_addr, .wr_ready, .rd_addr,
    .rd_word, .reset_pol);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic take(input logic [7:0] exp);
    int n;
    n = 0;
    #1;
    while (wr_valid !== 1'b1 && n < 40)
    begin
      @(posedge clock);
      #1 n++;
    end
    if (n == 40)
    begin
      fail_count++;
      summarize();
    end
    check(wr_data, exp);
    @(posedge clock);
    wr_ready <= 1'b1;
    @(posedge clock);
    wr_ready <= 1'b0;
  endtask : take
  task automatic t_enter();
    #1 check(8'({cascade_select_out, prog_mode, data_oe}), 8'h4);
    repeat (2) prg_u.tick(1'b1, 1'b1, 1'b0);
    #1 check(8'(rd_addr), 8'h0);
    prg_u.enter();
    #1 check(8'(prog_mode), 8'h1);
    $display("enter done");
  endtask : t_enter
  task automatic t_write();
    prg_u.commit(8'ha5);
    #1 check(8'(data_oe), 8'h0);
    prg_u.commit(8'h3c);
    take(8'ha5);
    take(8'h3c);
    $display("write done");
  endtask : t_write
  task automatic t_read();
    repeat (2) prg_u.tick(1'b1, 1'b0, 1'b0);
    #1 check(8'(rd_addr), 8'h2);
    @(posedge clock);
    reset_pol <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      prg_u.tick(1'b0, 1'b1, 1'b0);
      #1 w[i] = data_out;
    end
    check(8'(data_oe), 8'h1);
    check(w, 8'h2d);
    check(8'(cascade_select_out), 8'h0);
    @(posedge clock);
    reset_pol <= 1'b1;
    prg_u.tick(1'b1, 1'b1, 1'b0);
    #1 check(8'(cascade_select_out), 8'h1);
    $display("read done");
  endtask : t_read
  task automatic t_final();
    repeat (13 * 8) prg_u.tick(1'b0, 1'b1, 1'b0);
    #1 check(8'({cascade_select_out, data_oe}), 8'h3);
    prg_u.tick(1'b0, 1'b1, 1'b0);
    #1 check(8'({cascade_select_out, data_oe}), 8'h0);
    $display("final done");
  endtask : t_final
  task automatic t_exit();
    prg_u.tick(1'b0, 1'b0, 1'b0);
    #1 check(8'({prog_mode, data_oe}), 8'h0);
    $display("exit done");
  endtask : t_exit
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_enter();
    t_write();
    t_read();
    t_final();
    t_exit();
    summarize();
  end
endmodule : tb_prom_prog_port
`default_nettype wire
